// ### core/adc_input_select_scan.v
// Input selection, pin configuration and channel scan control for a
// 10-bit converter. Assumes an Avalon-MM master on the same 200 MHz clock,
// an instruction-cycle tick and a sample-start strobe from the converter.
`timescale 1ns/1ps
`default_nettype none
`include "adc_sel_regs.vh"

// How it works
// - First positive field picks channels 0-12, or 15 for band-gap.
// - Alternate setting has its own positive field in bits 11-8.
// - First negative input is channel one when bit 7 set, else reference.
// - Alternate negative input is channel one when bit 15 set.
// - Pin bit 1 means digital with port reads; 0 means analog sampling.
// - Pin config bit 15 set disables the band-gap reference.
// - Scan bits 12-0 include their channel in the scan.
// - Scan bit 15 includes the band-gap channel in the scan.
// - Unimplemented bits read zero and ignore writes.
// - Conversion clock period is instruction cycle times divider plus one.
// - That relation assumes an instruction cycle of two oscillator periods.
// - All implemented bits clear at reset.
// - Scan enable steps the first positive input through the scan-selected channels; otherwise no scan.
// - Alternate mode uses first setting, then alternates second and first.
// - Divider is 8 bits; code 0 is one cycle, code 1 is two.
module adc_input_select_scan #(
    parameter DIV_WIDTH = 8
) (
    input  wire                 clock,
    input  wire                 rstn,
    input  wire [4:0]           address,
    input  wire                 read,
    input  wire                 write,
    input  wire [31:0]          writedata,
    input  wire [3:0]           byteenable,
    output reg  [31:0]          readdata,
    output wire                 waitrequest,
    input  wire                 instr_tick,
    input  wire                 sample_start,
    output reg  [3:0]           pos_channel,
    output reg                  neg_is_channel_one,
    output reg                  using_alt_setting,
    output reg  [12:0]          pin_digital_mode,
    output reg                  bandgap_enable,
    output wire                 conv_clock_pulse,
    output reg                  sample_window
);
    reg [15:0] converter_input_select_reg;
    reg [15:0] analog_pin_config_reg;
    reg [15:0] scan_channel_select_reg;
    reg [15:0] conv_control_reg;
    reg [3:0]  scan_channel_reg;
    reg        alt_phase_reg;
    reg        ack_reg;
    reg [7:0]  sample_count_reg;
    reg [15:0] wmask;
    reg [15:0] wdata16;
    wire [3:0] scan_next;
    wire       scan_any;
    wire [DIV_WIDTH-1:0] divider;

    localparam integer SAMPLE_CYCLES_INT = `SAMPLE_CYCLES;
    localparam [7:0]   SAMPLE_CYCLES     = SAMPLE_CYCLES_INT[7:0];

    // One wait state on every access keeps read data registered.
    assign waitrequest = (read || write) && !ack_reg;

    always @* begin
        wmask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};
        wdata16 = writedata[15:0];
    end

    always @(posedge clock) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
        end
    end

    // Writes take effect at the edge where waitrequest is low.
    always @(posedge clock) begin
        if (!rstn) begin
            converter_input_select_reg <= `REG_RESET;
            analog_pin_config_reg      <= `REG_RESET;
            scan_channel_select_reg    <= `REG_RESET;
            conv_control_reg           <= `REG_RESET;
        end else if (write && ack_reg) begin
            if (address == `OFF_INPUT_SELECT) begin
                converter_input_select_reg <=
                    (converter_input_select_reg & ~(wmask & `INSEL_WMASK)) |
                    (wdata16 & wmask & `INSEL_WMASK);
            end else if (address == `OFF_PIN_CONFIG) begin
                analog_pin_config_reg <=
                    (analog_pin_config_reg & ~(wmask & `PCFG_WMASK)) |
                    (wdata16 & wmask & `PCFG_WMASK);
            end else if (address == `OFF_SCAN_SELECT) begin
                scan_channel_select_reg <=
                    (scan_channel_select_reg & ~(wmask & `SCAN_WMASK)) |
                    (wdata16 & wmask & `SCAN_WMASK);
            end else if (address == `OFF_CONV_CONTROL) begin
                conv_control_reg <=
                    (conv_control_reg & ~(wmask & `CTRL_WMASK)) |
                    (wdata16 & wmask & `CTRL_WMASK);
            end
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            readdata <= 32'h00000000;
        end else if (read && !ack_reg) begin
            if (address == `OFF_INPUT_SELECT) begin
                readdata <= {16'h0000, converter_input_select_reg};
            end else if (address == `OFF_PIN_CONFIG) begin
                readdata <= {16'h0000, analog_pin_config_reg};
            end else if (address == `OFF_SCAN_SELECT) begin
                readdata <= {16'h0000, scan_channel_select_reg};
            end else if (address == `OFF_CONV_CONTROL) begin
                readdata <= {16'h0000, conv_control_reg};
            end else if (address == `OFF_STATUS) begin
                readdata <= {26'h0000000, using_alt_setting,
                             sample_window, pos_channel};
            end else begin
                readdata <= 32'h00000000;
            end
        end
    end

    assign divider = conv_control_reg[`DIVIDER_LSB +: DIV_WIDTH];

    // Divider counts instruction-cycle ticks; tick rate is two oscillator
    // periods by assumption, so no doze or PLL scaling is applied here.
    conv_clock_div #(
        .WIDTH (DIV_WIDTH)
    ) u_div (
        .clock            (clock),
        .rstn             (rstn),
        .tick             (instr_tick),
        .divider          (divider),
        .conv_clock_pulse (conv_clock_pulse)
    );

    // Only bits 12-0 and 15 of the scan mask are ever set, so the search
    // never lands on an unimplemented code.
    scan_next_channel u_scan (
        .include_bits (scan_channel_select_reg & `SCAN_WMASK),
        .current      (scan_channel_reg),
        .next_channel (scan_next),
        .any_selected (scan_any)
    );

    // Selection is latched only on sample start, so a write during a
    // conversion does not disturb the inputs already in use.
    always @(posedge clock) begin
        if (!rstn) begin
            scan_channel_reg   <= 4'hF;
            alt_phase_reg      <= 1'b0;
            pos_channel        <= 4'h0;
            neg_is_channel_one <= 1'b0;
            using_alt_setting  <= 1'b0;
        end else if (sample_start) begin
            if (conv_control_reg[`ALT_MODE_BIT] && alt_phase_reg) begin
                using_alt_setting  <= 1'b1;
                pos_channel        <= converter_input_select_reg
                                      [`ALT_POS_LSB +: 4];
                neg_is_channel_one <=
                    converter_input_select_reg[`ALT_NEG_BIT];
            end else begin
                using_alt_setting  <= 1'b0;
                neg_is_channel_one <=
                    converter_input_select_reg[`FIRST_NEG_BIT];
                if (conv_control_reg[`SCAN_EN_BIT] && scan_any) begin
                    pos_channel      <= scan_next;
                    scan_channel_reg <= scan_next;
                end else begin
                    pos_channel <= converter_input_select_reg
                                   [`FIRST_POS_LSB +: 4];
                end
            end
            alt_phase_reg <= conv_control_reg[`ALT_MODE_BIT] &&
                             !alt_phase_reg;
        end else begin
            if (!conv_control_reg[`ALT_MODE_BIT]) begin
                alt_phase_reg <= 1'b0;
            end
            if (!conv_control_reg[`SCAN_EN_BIT]) begin
                scan_channel_reg <= 4'hF;
            end
        end
    end

    // Sample window stands a fixed number of cycles after each start.
    always @(posedge clock) begin
        if (!rstn) begin
            sample_count_reg <= 8'h00;
            sample_window    <= 1'b0;
        end else if (sample_start) begin
            sample_count_reg <= SAMPLE_CYCLES;
            sample_window    <= 1'b1;
        end else if (sample_count_reg > 8'h01) begin
            sample_count_reg <= sample_count_reg - 8'h01;
        end else begin
            sample_count_reg <= 8'h00;
            sample_window    <= 1'b0;
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            pin_digital_mode <= 13'h0000;
            bandgap_enable   <= 1'b1;
        end else begin
            pin_digital_mode <= analog_pin_config_reg[12:0];
            bandgap_enable   <=
                !analog_pin_config_reg[`BANDGAP_BIT];
        end
    end
endmodule
`default_nettype wire

// ### core/adc_sel_regs.vh
// Register offsets, field positions, reset values and timing for the input
// selection and scan block. Assumes a 32-bit Avalon-MM slave, word aligned.
`ifndef ADC_SEL_REGS_VH
`define ADC_SEL_REGS_VH

`define OFF_INPUT_SELECT   4'h0
`define OFF_PIN_CONFIG     4'h4
`define OFF_SCAN_SELECT    4'h8
`define OFF_CONV_CONTROL   4'hC
`define OFF_STATUS         5'h10

`define INSEL_WMASK        16'h8F8F
`define PCFG_WMASK         16'h9FFF
`define SCAN_WMASK         16'h9FFF
`define CTRL_WMASK         16'h03FF
`define REG_RESET          16'h0000

`define FIRST_POS_LSB      0
`define FIRST_NEG_BIT      7
`define ALT_POS_LSB        8
`define ALT_NEG_BIT        15
`define BANDGAP_BIT        15
`define DIVIDER_LSB        0
`define SCAN_EN_BIT        8
`define ALT_MODE_BIT       9

`define BANDGAP_CODE       4'hF
`define LAST_ANALOG_CODE   4'hC

`define SAMPLE_TIME_NS     100
`define CLOCK_PERIOD_NS    5
`define SAMPLE_CYCLES      ((`SAMPLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ### core/conv_clock_div.v
// Conversion clock divider: one pulse every (divider + 1) ticks.
// Assumes tick is one instruction cycle strobe on the same clock.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             rstn,
    input  wire             tick,
    input  wire [WIDTH-1:0] divider,
    output reg              conv_clock_pulse
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clock) begin
        if (!rstn) begin
            count_reg        <= {WIDTH{1'b0}};
            conv_clock_pulse <= 1'b0;
        end else begin
            conv_clock_pulse <= 1'b0;
            if (tick) begin
                if (count_reg >= divider) begin
                    count_reg        <= {WIDTH{1'b0}};
                    conv_clock_pulse <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### core/scan_next_channel.v
// Finds the next set bit above the current channel, wrapping around.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module scan_next_channel (
    input  wire [15:0] include_bits,
    input  wire [3:0]  current,
    output reg  [3:0]  next_channel,
    output reg         any_selected
);
    integer i;
    reg     found;
    reg [4:0] idx;

    always @* begin
        found        = 1'b0;
        next_channel = current;
        any_selected = |include_bits;
        idx          = 5'h00;
        for (i = 1; i <= 16; i = i + 1) begin
            idx = {1'b0, current} + i[4:0];
            if (!found && include_bits[idx[3:0]]) begin
                found        = 1'b1;
                next_channel = idx[3:0];
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/adc_input_select_scan_chk.sv
// Checker for the input selection block; it sees only the block's ports.
// Assumes the single clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_scan_chk (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        sample_start,
    input wire logic [3:0]  pos_channel,
    input wire logic        neg_is_channel_one,
    input wire logic        using_alt_setting,
    input wire logic [12:0] pin_digital_mode,
    input wire logic        bandgap_enable,
    input wire logic        conv_clock_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_pin_wr;
        write && !waitrequest && address == 5'h04 && byteenable[1:0] == 2'h3;
    endsequence
    sequence s_sel_rd;
        read && !waitrequest && address == 5'h00;
    endsequence
    property p_pins;
        s_pin_wr |-> ##2 pin_digital_mode == $past(writedata[12:0], 2);
    endproperty
    a_pins: assert property (p_pins) else $error("pin mode wrong");
    property p_bgap;
        s_pin_wr |-> ##2 bandgap_enable != $past(writedata[15], 2);
    endproperty
    a_bgap: assert property (p_bgap) else $error("band-gap wrong");
    property p_unimp;
        s_sel_rd |-> readdata[31:16] == 16'h0000 &&
            readdata[14:12] == 3'h0 && readdata[6:4] == 3'h0;
    endproperty
    a_unimp: assert property (p_unimp) else $error("unused bits set");
    property p_init;
        $rose(rstn) |-> bandgap_enable && pin_digital_mode == 13'h0;
    endproperty
    a_init: assert property (p_init) else $error("reset state wrong");
    // Selections may only move on a sample, never mid-conversion.
    property p_hold;
        !sample_start |=> $stable({pos_channel, neg_is_channel_one,
                                   using_alt_setting});
    endproperty
    a_hold: assert property (p_hold) else $error("mux moved");
    property p_code;
        pos_channel <= 4'hC || pos_channel == 4'hF;
    endproperty
    a_code: assert property (p_code) else $error("bad channel");
    property p_alt;
        $rose(using_alt_setting) |-> $past(sample_start);
    endproperty
    a_alt: assert property (p_alt) else $error("alt too early");
    property p_pulse;
        conv_clock_pulse |=> !conv_clock_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too long");
endmodule
bind adc_input_select_scan adc_input_select_scan_chk i_adc_input_select_scan_chk (
    .clock, .rstn, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .sample_start, .pos_channel,
    .neg_is_channel_one, .using_alt_setting, .pin_digital_mode,
    .bandgap_enable, .conv_clock_pulse);
`default_nettype wire

// ### verification/adc_input_select_scan_test.sv
// Self-checking bench for the input selection block.
// Assumes the one-wait-cycle Avalon-MM slave and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_scan_test;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic        instr_tick = 1'b0;
    logic        sample_start = 1'b0;
    logic        st = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [3:0]  pos_channel;
    logic        neg_is_channel_one;
    logic        using_alt_setting;
    logic [12:0] pin_digital_mode;
    logic        bandgap_enable;
    logic        conv_clock_pulse;
    logic        sample_window;
    logic [31:0] rdq[$];
    logic [5:0]  chq[$];
    logic [31:0] v;
    logic [31:0] divs[4] = '{32'h0, 32'h1, 32'h3, 32'h7};
    logic [3:0]  scan[4] = '{4'h0, 4'hC, 4'hF, 4'h0};
    int          mismatches = 0;
    int          total_checks = 0;
    int          pulses = 0;
    int          p0;
    always #2.5 clock = ~clock;
    adc_input_select_scan i_adc_input_select_scan (
        .clock, .rstn, .address, .read, .write, .writedata,
        .byteenable(4'hF), .readdata, .waitrequest, .instr_tick,
        .sample_start, .pos_channel, .neg_is_channel_one, .using_alt_setting,
        .pin_digital_mode, .bandgap_enable, .conv_clock_pulse,
        .sample_window);
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // For a read, d carries the value the monitor must see.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        if (!wr)
            rdq.push_back(d);
        // The transfer ends at the first rising edge that sees waitrequest
        // low, and the request drops right after that same edge.
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            mismatches++;
            close_out();
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic smp(input logic [5:0] exp);
        chq.push_back(exp);
        @(posedge clock);
        sample_start <= 1'b1;
        @(posedge clock);
        sample_start <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    // Ticks two clocks apart stand for two oscillator periods per cycle.
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock);
            instr_tick <= 1'b1;
            @(posedge clock);
            instr_tick <= 1'b0;
        end
    endtask
    always @(posedge clock) begin
        st <= sample_start;
        if (conv_clock_pulse === 1'b1)
            pulses <= pulses + 1;
    end
    always @(posedge clock) begin
        if (read === 1'b1 && waitrequest === 1'b0 && rdq.size() > 0)
            check("readdata", rdq.pop_front(), readdata);
    end
    always @(negedge clock) begin
        if (st === 1'b1 && chq.size() > 0) begin
            check("mux", {26'h0, chq.pop_front()}, {26'h0, using_alt_setting,
                  neg_is_channel_one, pos_channel});
            check("window", 32'h1, {31'h0, sample_window});
        end
    end
    initial begin
        v = $urandom(32'hA6073CE9);
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        bus(0, 5'h00, 32'h0);
        bus(0, 5'h04, 32'h0);
        bus(0, 5'h08, 32'h0);
        bus(0, 5'h14, 32'h0);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            v[3:0] = v[3:0] % 13;
            v[11:8] = v[11:8] % 13;
            bus(1, 5'h00, v);
            bus(0, 5'h00, v & 32'h8F8F);
            bus(1, 5'h04, v);
            bus(0, 5'h04, v & 32'h9FFF);
            bus(1, 5'h08, v);
            bus(0, 5'h08, v & 32'h9FFF);
        end
        bus(1, 5'h04, 32'h01C0);
        bus(0, 5'h04, 32'h01C0);
        bus(1, 5'h0C, 32'h0);
        bus(1, 5'h08, 32'h0);
        bus(1, 5'h00, 32'h0985);
        smp(6'h15);
        bus(1, 5'h00, 32'h8F0F);
        smp(6'h0F);
        bus(1, 5'h00, 32'h8C8B);
        bus(1, 5'h0C, 32'h200);
        smp(6'h1B);
        smp(6'h3C);
        bus(1, 5'h00, 32'h0C8B);
        smp(6'h1B);
        smp(6'h2C);
        bus(0, 5'h10, 32'h3C);
        bus(1, 5'h0C, 32'h0);
        bus(1, 5'h08, 32'h9001);
        bus(1, 5'h00, 32'h0);
        bus(1, 5'h0C, 32'h100);
        foreach (scan[i])
            smp({2'h0, scan[i]});
        foreach (divs[i]) begin
            bus(1, 5'h0C, divs[i]);
            ticks(8);
            // Two edges let the last warm-up pulse reach the counter first.
            repeat (2) @(negedge clock);
            p0 = pulses;
            ticks(16);
            repeat (4) @(posedge clock);
            check("pulses", 32'h10 / (divs[i] + 1), 32'(pulses - p0));
        end
        close_out();
    end
endmodule
`default_nettype wire
